// ==== src/pph_top.sv ====
// Host side handshake of a multi-mode parallel port
// Behaviour
// R1: FIFO mode paces bytes by busy only
// R2: Forward idle keeps strobe high
// R3: Peripheral request sampled through synchroniser
// R4: Strobe falls only when busy low; the EPP write strobe waits on wait low instead, not on busy
// R5: Strobe rises after busy; byte done on busy low
// R6: Reverse idle keeps host ack low
// R7: Write line high outside write cycle
// R8: Wait input settles after 50 ns quiet
// R9: Peripheral releases wait within 10 us
// R10: Reverse interlock on host ack and peripheral clock
// R11: All cable inputs pass two flip-flops
`timescale 1ns/1ps
module pph_top (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_mode,
    input wire logic i_reverse,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [pph_pkg::DATA_W-1:0] i_in_data,
    output logic o_rx_valid,
    output logic [pph_pkg::DATA_W-1:0] o_rx_data,
    input wire logic i_busy,
    input wire logic i_ack_n,
    input wire logic i_fault_n,
    input wire logic i_wait_n,
    input wire logic [pph_pkg::DATA_W-1:0] i_pd,
    output logic [pph_pkg::DATA_W-1:0] o_pd,
    output logic o_pd_oe,
    output logic o_strobe_n,
    output logic o_host_ack,
    output logic o_write_n,
    output logic o_periph_req
);
    import pph_pkg::*;
    localparam int SW = $clog2(WAIT_SETTLE_CYC + 1);
    pph_state_type st_reg, st_next;
    logic [3:0] s1_reg, s2_reg;
    logic [DATA_W-1:0] pd1_reg, pd2_reg;
    logic wait_last_reg, wait_reg;
    logic [SW-1:0] quiet_reg;
    logic [DATA_W-1:0] fd;
    logic fv, fpop;
    // Drive states pull the strobe low
    function automatic logic pph_strobe_state(input pph_state_type s);
        return (s == ST_STRB) || (s == ST_EPPW);
    endfunction : pph_strobe_state
    // Reverse states hand the data lines to the peripheral
    function automatic logic pph_rev_state(input pph_state_type s);
        return (s == ST_RVWT) || (s == ST_RVAK);
    endfunction : pph_rev_state
    // Two flip-flop synchroniser on every cable input
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= SYNC_IDLE; // R11
            s2_reg <= SYNC_IDLE;
            pd1_reg <= '0;
            pd2_reg <= '0;
        end else begin
            s1_reg <= {i_wait_n, i_fault_n, i_ack_n, i_busy}; // R3
            s2_reg <= s1_reg;
            pd1_reg <= i_pd;
            pd2_reg <= pd1_reg;
        end
    end
    wire busy_s = s2_reg[0];
    wire ack_s = s2_reg[1];
    wire fault_s = s2_reg[2];
    wire wait_s = s2_reg[3];
    // Wait filter: accept a level only after it stays quiet
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_last_reg <= 1'b1;
            quiet_reg <= '0;
            wait_reg <= 1'b1;
        end else begin
            wait_last_reg <= wait_s;
            if (wait_s != wait_last_reg) quiet_reg <= '0; // R8
            else if (quiet_reg != SW'(WAIT_SETTLE_CYC))
                quiet_reg <= quiet_reg + 1'b1;
            if (quiet_reg == SW'(WAIT_SETTLE_CYC)) wait_reg <= wait_last_reg;
        end
    end
    pph_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_in_valid),
        .o_in_ready(o_in_ready),
        .i_in_data(i_in_data),
        .o_out_valid(fv),
        .i_out_ready(fpop),
        .o_out_data(fd)
    );
    // Byte leaves the FIFO when its strobe is launched
    assign fpop = (st_reg == ST_IDLE) && (st_next == ST_STRB)
        || (st_reg == ST_IDLE) && (st_next == ST_EPPW);
    // Reverse byte is taken when the peripheral clock returns high
    wire rev_take = (st_reg == ST_RVAK) && ack_s;
    // Next state decode
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE: begin
                if (i_reverse && i_mode == MODE_ECP) st_next = ST_RVWT;
                else if (fv && i_mode == MODE_EPP && !wait_reg)
                    st_next = ST_EPPW;
                else if (fv && i_mode != MODE_EPP && !busy_s)
                    st_next = ST_STRB; // R1 R4
            end
            ST_STRB: if (busy_s) st_next = ST_DONE; // R5
            ST_DONE: begin
                if (i_mode == MODE_FIFO || !busy_s)
                    st_next = ST_IDLE; // R1 R5
            end
            ST_RVWT: begin
                if (!ack_s) st_next = ST_RVAK; // R10
                else if (!i_reverse) st_next = ST_IDLE; // R6
            end
            ST_RVAK: if (ack_s) st_next = ST_RVWT; // R10
            ST_EPPW: if (wait_reg) st_next = ST_IDLE; // R9
            default: st_next = ST_IDLE;
        endcase
    end
    // State and registered pin outputs
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= ST_IDLE;
            o_strobe_n <= 1'b1;
            o_host_ack <= 1'b0;
            o_write_n <= 1'b1;
            o_pd <= '0;
            o_pd_oe <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_data <= '0;
            o_periph_req <= 1'b0;
        end else begin
            st_reg <= st_next;
            o_strobe_n <= !pph_strobe_state(st_next); // R2
            o_host_ack <= (st_next == ST_RVAK); // R6 R10
            o_write_n <= (st_next != ST_EPPW); // R7
            o_pd_oe <= !pph_rev_state(st_next);
            if (fpop) o_pd <= fd; // R4
            o_rx_valid <= rev_take; // R10
            if (rev_take) o_rx_data <= pd2_reg;
            o_periph_req <= !fault_s; // R3
        end
    end
    // Steps of the forward interlock
    sequence s_fwd_launch;
        (st_reg == ST_IDLE) && (st_next == ST_STRB);
    endsequence
    sequence s_fwd_ack;
        (st_reg == ST_STRB) && busy_s;
    endsequence
    sequence s_epp_hold;
        (st_reg == ST_EPPW) && !wait_reg;
    endsequence
    // Steps of the reverse interlock
    sequence s_rev_clk_low;
        (st_reg == ST_RVWT) && !ack_s;
    endsequence
    sequence s_rev_clk_high;
        rev_take;
    endsequence
    // Checks
    a_strobe_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg == ST_IDLE && !fpop) |=> o_strobe_n) // R2
        else $error("strobe low while idle");
    a_strobe_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(o_strobe_n) && o_write_n |-> $past(!busy_s)) // R4
        else $error("strobe fell while busy");
    a_strobe_rise: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg == ST_STRB && busy_s) |=> o_strobe_n) // R5
        else $error("strobe not released after busy");
    a_fifo_noack: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg == ST_DONE && i_mode == MODE_FIFO) |=> st_reg == ST_IDLE) // R1
        else $error("fifo mode waited");
    a_write_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg != ST_EPPW) |-> o_write_n) // R7
        else $error("write low outside cycle");
    a_wait_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $changed(wait_reg) |-> $past(quiet_reg) == SW'(WAIT_SETTLE_CYC)) // R8
        else $error("wait accepted unsettled");
    a_rev_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg == ST_RVWT) |-> !o_host_ack) // R6
        else $error("host ack high in reverse idle");
    a_rev_take: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_rev_clk_high |=> o_rx_valid ##1 !o_host_ack) // R10
        else $error("reverse byte not taken");
    a_req_sync: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_periph_req == !$past(fault_s)) // R11
        else $error("request not synchronised");
    // Interlock checks, some built from the sequences and some from state and pin terms
    a_strobe_launch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_fwd_launch |=> !o_strobe_n && o_pd == $past(fd)) // R4
        else $error("strobe or data missing at launch");
    a_strobe_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg == ST_STRB) && !busy_s |=> !o_strobe_n) // R5
        else $error("strobe released before busy");
    a_fwd_release: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_fwd_ack |=> o_strobe_n && (st_reg == ST_DONE)) // R5
        else $error("forward release missed");
    a_done_wait: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg == ST_DONE && i_mode != MODE_FIFO && busy_s)
        |=> (st_reg == ST_DONE)) // R5
        else $error("byte ended while busy");
    a_strobe_oe: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_strobe_n |-> o_pd_oe) // R4
        else $error("strobe low with data released");
    a_epp_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_epp_hold |=> !o_write_n && !o_strobe_n) // R7
        else $error("write cycle ended early");
    a_rev_ack_rise: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_rev_clk_low |=> o_host_ack) // R10
        else $error("host ack not raised");
    a_pd_oe_rev: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_reg == ST_RVAK) |-> !o_pd_oe) // R10
        else $error("data driven in reverse");
    a_rx_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_rev_clk_high |=> o_rx_data == $past(pd2_reg)) // R10
        else $error("reverse byte not latched");
endmodule : pph_top

// ==== src/pph_pkg.sv ====
// Package: constants and modes of the parallel port handshake block
package pph_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    // Settle time on the wait input, least time, rounded up
    localparam int WAIT_SETTLE_PS = 50000;
    localparam int WAIT_SETTLE_CYC =
        (WAIT_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    // Idle levels of {wait, request, peripheral clock, busy} after reset
    localparam logic [3:0] SYNC_IDLE = 4'he;
    localparam logic [1:0] MODE_FIFO = 2'h0;
    localparam logic [1:0] MODE_ECP = 2'h1;
    localparam logic [1:0] MODE_EPP = 2'h2;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_STRB = 6'h02,
        ST_DONE = 6'h04,
        ST_RVWT = 6'h08,
        ST_RVAK = 6'h10,
        ST_EPPW = 6'h20
    } pph_state_type;
endpackage : pph_pkg

// ==== src/pph_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module pph_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;
    wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    logic rdy_reg;
    // Ready is registered from the next count; empty from the count
    assign o_in_ready = rdy_reg;
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem_reg[rd_reg];
    // Storage writes
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end
    // Pointers and count
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            rdy_reg <= 1'b1;
        end else begin
            if (push) wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            if (pop) rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_next;
            rdy_reg <= (cnt_next != DEPTH[AW:0]);
        end
    end
endmodule : pph_fifo

// ==== test/pph_periph.sv ====
// Cable peripheral model: interlocked busy, wait and reverse clock
`timescale 1ns/1ps
module pph_periph (
    input wire logic i_mclk,
    input wire logic i_strobe_n,
    input wire logic i_host_ack,
    input wire logic [7:0] i_pd,
    input wire logic i_stall,
    input wire logic i_req,
    input wire logic i_send,
    input wire logic [7:0] i_tx_byte,
    output logic o_busy = 1'b0,
    output logic o_wait_n = 1'b0,
    output logic o_ack_n = 1'b1,
    output logic o_fault_n,
    output logic [7:0] o_pd = 8'hff
);
    logic [7:0] got[$];
    // Request line follows the bench, asynchronous to the host clock
    assign o_fault_n = !i_req;
    // Acknowledge each strobe; a stall keeps busy high
    always begin
        @(negedge i_strobe_n);
        repeat (3) @(posedge i_mclk);
        #7 o_busy = 1'b1;
        o_wait_n = 1'b1;
        @(posedge i_strobe_n);
        got.push_back(i_pd);
        while (i_stall) @(posedge i_mclk);
        repeat (2) @(posedge i_mclk);
        #7 o_busy = 1'b0;
        o_wait_n = 1'b0;
    end
    // One reverse byte, interlocked with the host acknowledge
    always @(posedge i_send) begin
        o_pd = i_tx_byte;
        #100 o_ack_n = 1'b0;
        @(posedge i_host_ack);
        #100 o_ack_n = 1'b1;
        @(negedge i_host_ack);
        o_pd = ~i_tx_byte;
    end
endmodule : pph_periph

// ==== test/pph_top_bench.sv ====
// Self-checking bench of the parallel port handshake block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    error_cnt++; $display("MISMATCH %0t value differs", $time); end end
module pph_top_bench;
    import pph_pkg::*;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_reverse = 1'b0;
    logic [1:0] i_mode = MODE_FIFO;
    logic i_in_valid = 1'b0, i_stall = 1'b0, i_req = 1'b0, i_send = 1'b0;
    logic [7:0] i_in_data = 8'h00, i_tx_byte = 8'h00, o_rx_data, o_pd, pd;
    logic o_in_ready, o_rx_valid, busy, ack_n, fault_n, wait_n, o_pd_oe;
    logic o_strobe_n, o_host_ack, o_write_n, o_periph_req;
    int error_cnt = 0, cmp_count = 0;
    pph_top i_pph_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode(i_mode),
        .i_reverse(i_reverse), .i_in_valid(i_in_valid),
        .o_in_ready(o_in_ready), .i_in_data(i_in_data),
        .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_busy(busy),
        .i_ack_n(ack_n), .i_fault_n(fault_n), .i_wait_n(wait_n),
        .i_pd(pd), .o_pd(o_pd), .o_pd_oe(o_pd_oe), .o_strobe_n(o_strobe_n),
        .o_host_ack(o_host_ack), .o_write_n(o_write_n),
        .o_periph_req(o_periph_req));
    pph_periph i_pph_periph (.i_mclk(i_mclk), .i_strobe_n(o_strobe_n),
        .i_host_ack(o_host_ack), .i_pd(o_pd), .i_stall(i_stall),
        .i_req(i_req), .i_send(i_send), .i_tx_byte(i_tx_byte),
        .o_busy(busy), .o_wait_n(wait_n), .o_ack_n(ack_n),
        .o_fault_n(fault_n), .o_pd(pd));
    // Clock at 40 MHz
    initial forever #12.5 i_mclk = ~i_mclk;
    task automatic report_and_stop();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // Wait a bounded number of edges for the peripheral to log n bytes
    task automatic wait_got(input int n);
        int k;
        for (k = 0; k < 2000 && i_pph_periph.got.size() < n; k++) begin
            @(posedge i_mclk);
        end
        #2;
        if (k == 2000) begin
            error_cnt++;
            $display("MISMATCH %0t peripheral byte timeout", $time);
            report_and_stop();
        end
    endtask : wait_got
    // Three bytes forward in one mode, data order and idle levels
    task automatic fwd_run(input logic [1:0] m);
        i_mode = m;
        i_pph_periph.got.delete();
        i_in_valid = 1'b1;
        for (int k = 0; k < 3; k++) begin
            i_in_data = {m, 6'h15} + 8'(k);
            do @(posedge i_mclk); while (o_in_ready !== 1'b1);
            #2;
        end
        i_in_valid = 1'b0;
        wait_got(3);
        repeat (8) @(posedge i_mclk);
        #2;
        for (int k = 0; k < 3; k++)
            `CHK(i_pph_periph.got[k], {m, 6'h15} + 8'(k))
        `CHK(o_strobe_n, 1'b1)
        `CHK(o_write_n, 1'b1)
    endtask : fwd_run
    // Stall the peripheral, fill the buffer until refused, then drain
    task automatic fill_drain();
        int acc;
        acc = 0;
        i_mode = MODE_ECP;
        i_stall = 1'b1;
        i_pph_periph.got.delete();
        i_in_valid = 1'b1;
        for (int k = 0; k < 16; k++) begin
            i_in_data = 8'h40 + 8'(acc);
            if (o_in_ready === 1'b1) acc++;
            @(posedge i_mclk);
            #2;
        end
        i_in_valid = 1'b0;
        `CHK(acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 2, 1'b1)
        `CHK(o_in_ready, 1'b0)
        i_stall = 1'b0;
        wait_got(acc);
        for (int k = 0; k < acc; k++)
            `CHK(i_pph_periph.got[k], 8'h40 + 8'(k))
    endtask : fill_drain
    // One reverse byte in the ECP mode
    task automatic reverse_byte();
        int k;
        i_mode = MODE_ECP;
        i_reverse = 1'b1;
        repeat (4) @(posedge i_mclk);
        #2;
        `CHK(o_host_ack, 1'b0)
        i_tx_byte = 8'h5a;
        i_send = 1'b1;
        for (k = 0; k < 200 && o_rx_valid !== 1'b1; k++) begin
            @(posedge i_mclk);
            #2;
        end
        `CHK(o_rx_valid, 1'b1)
        if (k == 200) report_and_stop();
        `CHK(o_rx_data, 8'h5a)
        `CHK(o_pd_oe, 1'b0)
        repeat (6) @(posedge i_mclk);
        #2;
        `CHK(o_host_ack, 1'b0)
        i_send = 1'b0;
        i_reverse = 1'b0;
    endtask : reverse_byte
    // Peripheral request seen through the synchroniser
    task automatic periph_request();
        i_req = 1'b1;
        repeat (2) @(posedge i_mclk);
        #2;
        `CHK(o_periph_req, 1'b0)
        repeat (3) @(posedge i_mclk);
        #2;
        `CHK(o_periph_req, 1'b1)
        i_req = 1'b0;
        repeat (4) @(posedge i_mclk);
        #2;
        `CHK(o_periph_req, 1'b0)
    endtask : periph_request
    initial begin
        repeat (2) @(posedge i_mclk);
        `CHK(o_strobe_n, 1'b1)
        `CHK(o_write_n, 1'b1)
        `CHK(o_host_ack, 1'b0)
        #2 i_rst_n = 1'b1;
        fwd_run(MODE_FIFO);
        fwd_run(MODE_ECP);
        fwd_run(MODE_EPP);
        fill_drain();
        reverse_byte();
        periph_request();
        report_and_stop();
    end
endmodule : pph_top_bench
